// ### pkg/eobd_pkg.sv
// Constants, types and functional notes for the opcode decoder
package eobd_pkg;

	// ------------------------------------------------------------
	// Prefix and special codes
	// ------------------------------------------------------------
	localparam logic [7:0] EOBD_PFX_BIT   = 8'h00CB;
	localparam logic [7:0] EOBD_PFX_IDX1  = 8'h00DD;
	localparam logic [7:0] EOBD_PFX_EXT   = 8'h00ED;
	localparam logic [7:0] EOBD_PFX_IDX2  = 8'h00FD;
	localparam logic [7:0] EOBD_OP_HALT   = 8'h0076;
	localparam logic [7:0] EOBD_OP_DIS    = 8'h00F3;
	localparam logic [7:0] EOBD_OP_ENA    = 8'h00FB;
	localparam logic [7:0] EOBD_OP_OUTN   = 8'h00D3;
	localparam logic [7:0] EOBD_OP_INN    = 8'h00DB;
	localparam logic [7:0] EOBD_OP_EXAF   = 8'h0008;
	localparam logic [7:0] EOBD_OP_PAIRSW = 8'h00D9;
	localparam logic [7:0] EOBD_OP_DECBR  = 8'h0010;
	localparam logic [7:0] EOBD_EXT_IM0   = 8'h0046;
	localparam logic [7:0] EOBD_EXT_IM1   = 8'h0056;
	localparam logic [7:0] EOBD_EXT_IM2   = 8'h005E;
	localparam logic [7:0] EOBD_EXT_RETM  = 8'h004D;
	localparam logic [7:0] EOBD_EXT_RETNM = 8'h0045;
	localparam logic [7:0] EOBD_EXT_BLKLO = 8'h00A0;
	localparam logic [7:0] EOBD_EXT_BLKHI = 8'h00BB;
	localparam logic [7:0] EOBD_BR_ADJ    = 8'h0002;
	localparam logic [2:0] EOBD_MEM_REG   = 3'h6;
	localparam logic [2:0] EOBD_SHIFT_GAP = 3'h6;

	// ------------------------------------------------------------
	// Operation classes reported to the datapath
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		EOBD_C_MISC      = 5'b00000,
		EOBD_C_LOAD8     = 5'b00001,
		EOBD_C_ALU       = 5'b00010,
		EOBD_C_HALT      = 5'b00011,
		EOBD_C_SHIFT     = 5'b00100,
		EOBD_C_BITTEST   = 5'b00101,
		EOBD_C_BITCLR    = 5'b00110,
		EOBD_C_BITSET    = 5'b00111,
		EOBD_C_UNDEF     = 5'b01000,
		EOBD_C_IMODE     = 5'b01001,
		EOBD_C_IDIS      = 5'b01010,
		EOBD_C_IENA      = 5'b01011,
		EOBD_C_RETM      = 5'b01100,
		EOBD_C_RETNM     = 5'b01101,
		EOBD_C_BLOCK     = 5'b01110,
		EOBD_C_RESTART   = 5'b01111,
		EOBD_C_PORTOUT   = 5'b10000,
		EOBD_C_PORTIN    = 5'b10001,
		EOBD_C_EXAF      = 5'b10010,
		EOBD_C_PAIRSW    = 5'b10011,
		EOBD_C_RELBR     = 5'b10100,
		EOBD_C_EXTOTHER  = 5'b10101
	} eobd_class_t;

	// Which register stands in for the pointer pair
	typedef enum logic [1:0] {
		EOBD_X_PTR  = 2'b00,
		EOBD_X_IDX1 = 2'b01,
		EOBD_X_IDX2 = 2'b10
	} eobd_idx_t;

	// Decoder sequencing states
	typedef enum logic [2:0] {
		EOBD_S_OPC  = 3'b000,
		EOBD_S_PFX2 = 3'b001,
		EOBD_S_DISP = 3'b010,
		EOBD_S_LO   = 3'b011,
		EOBD_S_HI   = 3'b100,
		EOBD_S_IMM  = 3'b101,
		EOBD_S_XCB  = 3'b110,
		EOBD_S_XOP  = 3'b111
	} eobd_state_t;

endpackage

// ### hdl/eobd_len.sv
// Operand length classifier for unprefixed and indexed opcodes
`timescale 1ns/1ps
module eobd_len
(
	input  wire logic [7:0] opc,
	input  wire logic       indexed,
	output logic            has_imm16,
	output logic            has_imm8,
	output logic            has_rel,
	output logic            has_disp
);
	// ------------------------------------------------------------
	// Field lookups
	// ------------------------------------------------------------
	wire [1:0] quad = opc[7:6];
	wire [2:0] mid  = opc[5:3];
	wire [2:0] low  = opc[2:0];

	assign has_imm16 = (quad == 2'd0 && low == 3'd1 && !opc[3])
		|| (quad == 2'd0 && low == 3'd2 && mid[2])
		|| (quad == 2'd3 && (low == 3'd2 || low == 3'd4))
		|| opc == 8'h00C3 || opc == 8'h00CD;

	assign has_imm8 = (quad == 2'd0 && low == 3'd6)
		|| (quad == 2'd3 && low == 3'd6)
		|| opc == eobd_pkg::EOBD_OP_OUTN || opc == eobd_pkg::EOBD_OP_INN;

	assign has_rel = quad == 2'd0 && low == 3'd0 && mid >= 3'd2;

	assign has_disp = indexed && (
		(quad == 2'd1 && (low == eobd_pkg::EOBD_MEM_REG
			|| mid == eobd_pkg::EOBD_MEM_REG) && opc != eobd_pkg::EOBD_OP_HALT)
		|| (quad == 2'd2 && low == eobd_pkg::EOBD_MEM_REG)
		|| opc == 8'h0034 || opc == 8'h0035 || opc == 8'h0036);

endmodule

// ### hdl/eobd_decoder.sv
// Byte-stream opcode decoder producing one decoded operation per instruction
`timescale 1ns/1ps
module eobd_decoder
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic [7:0]         byte_in,
	input  wire logic               byte_valid,
	output logic                    byte_ready,
	output logic                    op_valid,
	output eobd_pkg::eobd_class_t   op_class,
	output logic [7:0]              op_code,
	output eobd_pkg::eobd_idx_t     op_index,
	output logic [2:0]              op_group,
	output logic [2:0]              op_dst,
	output logic [2:0]              op_src,
	output logic [2:0]              op_bit,
	output logic [1:0]              op_imode,
	output logic [7:0]              op_vector,
	output logic [15:0]             op_operand,
	output logic [7:0]              op_disp,
	output logic                    op_uses_disp
);
	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	eobd_pkg::eobd_state_t state;
	eobd_pkg::eobd_state_t next_state;
	eobd_pkg::eobd_idx_t   idx;
	logic                  in_ext;
	logic [7:0]            opc;
	logic [7:0]            disp;
	logic [7:0]            lo;
	logic                  need_imm8;

	// Always able to accept: the decoder never stalls its source
	assign byte_ready = 1'b1;
	wire take = byte_valid;

	// ------------------------------------------------------------
	// Length classifier on the current byte
	// ------------------------------------------------------------
	logic len_imm16;
	logic len_imm8;
	logic len_rel;
	logic len_disp;

	eobd_len u_len
	(
		.opc       (byte_in),
		.indexed   (idx != eobd_pkg::EOBD_X_PTR),
		.has_imm16 (len_imm16),
		.has_imm8  (len_imm8),
		.has_rel   (len_rel),
		.has_disp  (len_disp)
	);

	// Decoding of a bit-prefix operation byte, used twice
	function automatic eobd_pkg::eobd_class_t bit_class(input logic [7:0] b);
		case (b[7:6])
			2'd0: bit_class = (b[5:3] == eobd_pkg::EOBD_SHIFT_GAP)
				? eobd_pkg::EOBD_C_UNDEF : eobd_pkg::EOBD_C_SHIFT;
			2'd1: bit_class = eobd_pkg::EOBD_C_BITTEST;
			2'd2: bit_class = eobd_pkg::EOBD_C_BITCLR;
			default: bit_class = eobd_pkg::EOBD_C_BITSET;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Unprefixed and indexed classification
	// ------------------------------------------------------------
	wire [1:0] quad = byte_in[7:6];
	wire       is_restart = quad == 2'd3 && byte_in[2:0] == 3'd7;
	wire       is_bitpfx  = byte_in == eobd_pkg::EOBD_PFX_BIT;
	wire       is_idxpfx  = byte_in == eobd_pkg::EOBD_PFX_IDX1
		|| byte_in == eobd_pkg::EOBD_PFX_IDX2;
	wire       is_extpfx  = byte_in == eobd_pkg::EOBD_PFX_EXT;
	eobd_pkg::eobd_class_t main_class;
	eobd_pkg::eobd_class_t ext_class;

	always_comb
	begin
		main_class = eobd_pkg::EOBD_C_MISC;
		if (byte_in == eobd_pkg::EOBD_OP_HALT)
			main_class = eobd_pkg::EOBD_C_HALT;
		else if (quad == 2'd1)
			main_class = eobd_pkg::EOBD_C_LOAD8;
		else if (quad == 2'd2)
			main_class = eobd_pkg::EOBD_C_ALU;
		else if (byte_in == eobd_pkg::EOBD_OP_DIS)
			main_class = eobd_pkg::EOBD_C_IDIS;
		else if (byte_in == eobd_pkg::EOBD_OP_ENA)
			main_class = eobd_pkg::EOBD_C_IENA;
		else if (is_restart)
			main_class = eobd_pkg::EOBD_C_RESTART;
		else if (byte_in == eobd_pkg::EOBD_OP_OUTN)
			main_class = eobd_pkg::EOBD_C_PORTOUT;
		else if (byte_in == eobd_pkg::EOBD_OP_INN)
			main_class = eobd_pkg::EOBD_C_PORTIN;
		else if (byte_in == eobd_pkg::EOBD_OP_EXAF)
			main_class = eobd_pkg::EOBD_C_EXAF;
		else if (byte_in == eobd_pkg::EOBD_OP_PAIRSW)
			main_class = eobd_pkg::EOBD_C_PAIRSW;
		else if (len_rel)
			main_class = eobd_pkg::EOBD_C_RELBR;
	end

	// Extended map, second byte
	always_comb
	begin
		ext_class = eobd_pkg::EOBD_C_EXTOTHER;
		if (byte_in == eobd_pkg::EOBD_EXT_IM0 || byte_in == eobd_pkg::EOBD_EXT_IM1
			|| byte_in == eobd_pkg::EOBD_EXT_IM2)
			ext_class = eobd_pkg::EOBD_C_IMODE;
		else if (byte_in == eobd_pkg::EOBD_EXT_RETM)
			ext_class = eobd_pkg::EOBD_C_RETM;
		else if (byte_in == eobd_pkg::EOBD_EXT_RETNM)
			ext_class = eobd_pkg::EOBD_C_RETNM;
		else if (byte_in >= eobd_pkg::EOBD_EXT_BLKLO
			&& byte_in <= eobd_pkg::EOBD_EXT_BLKHI && !byte_in[2])
			ext_class = eobd_pkg::EOBD_C_BLOCK;
	end

	wire [1:0] imode_sel = (byte_in == eobd_pkg::EOBD_EXT_IM0) ? 2'd0
		: (byte_in == eobd_pkg::EOBD_EXT_IM1) ? 2'd1 : 2'd2;
	// Extended forms with a 16-bit address: x3 and xB in rows 4..7
	wire ext_imm16 = quad == 2'd1 && byte_in[2:0] == 3'd3;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	wire first_done = !(len_imm16 || len_imm8 || len_rel || len_disp);

	always_comb
	begin
		next_state = state;
		if (take)
		begin
			case (state)
				eobd_pkg::EOBD_S_OPC:
				begin
					if (is_bitpfx && idx != eobd_pkg::EOBD_X_PTR)
						next_state = eobd_pkg::EOBD_S_XCB;
					else if (is_bitpfx || is_extpfx)
						next_state = eobd_pkg::EOBD_S_PFX2;
					else if (is_idxpfx)
						next_state = eobd_pkg::EOBD_S_OPC;
					else if (len_disp)
						next_state = eobd_pkg::EOBD_S_DISP;
					else if (len_imm16)
						next_state = eobd_pkg::EOBD_S_LO;
					else if (len_imm8 || len_rel)
						next_state = eobd_pkg::EOBD_S_IMM;
				end
				eobd_pkg::EOBD_S_PFX2:
					next_state = (in_ext && ext_imm16) ? eobd_pkg::EOBD_S_LO
						: eobd_pkg::EOBD_S_OPC;
				eobd_pkg::EOBD_S_DISP:
					next_state = need_imm8 ? eobd_pkg::EOBD_S_IMM : eobd_pkg::EOBD_S_OPC;
				eobd_pkg::EOBD_S_LO:  next_state = eobd_pkg::EOBD_S_HI;
				eobd_pkg::EOBD_S_HI:  next_state = eobd_pkg::EOBD_S_OPC;
				eobd_pkg::EOBD_S_IMM: next_state = eobd_pkg::EOBD_S_OPC;
				eobd_pkg::EOBD_S_XCB: next_state = eobd_pkg::EOBD_S_XOP;
				eobd_pkg::EOBD_S_XOP: next_state = eobd_pkg::EOBD_S_OPC;
				default:              next_state = eobd_pkg::EOBD_S_OPC;
			endcase
		end
	end

	// Instruction completes on this byte
	wire finish = take && (
		(state == eobd_pkg::EOBD_S_OPC && !is_bitpfx && !is_extpfx && !is_idxpfx
			&& first_done)
		|| (state == eobd_pkg::EOBD_S_PFX2 && !(in_ext && ext_imm16))
		|| (state == eobd_pkg::EOBD_S_DISP && !need_imm8)
		|| state == eobd_pkg::EOBD_S_HI || state == eobd_pkg::EOBD_S_IMM
		|| state == eobd_pkg::EOBD_S_XOP);

	// ------------------------------------------------------------
	// Context registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= eobd_pkg::EOBD_S_OPC;
			idx <= eobd_pkg::EOBD_X_PTR;
			in_ext <= 1'b0;
			opc <= 8'h0000;
			disp <= 8'h0000;
			lo <= 8'h0000;
			need_imm8 <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (finish)
				idx <= eobd_pkg::EOBD_X_PTR;
			else if (take && state == eobd_pkg::EOBD_S_OPC && is_idxpfx)
				idx <= byte_in[5] ? eobd_pkg::EOBD_X_IDX2 : eobd_pkg::EOBD_X_IDX1;
			if (take && state == eobd_pkg::EOBD_S_OPC)
			begin
				in_ext <= is_extpfx;
				opc <= byte_in;
				need_imm8 <= len_imm8;
			end
			if (take && state == eobd_pkg::EOBD_S_PFX2)
				opc <= byte_in;
			if (take && (state == eobd_pkg::EOBD_S_DISP || state == eobd_pkg::EOBD_S_XCB))
				disp <= byte_in;
			if (take && state == eobd_pkg::EOBD_S_LO)
				lo <= byte_in;
		end
	end

	// ------------------------------------------------------------
	// Output selection for the finishing byte
	// ------------------------------------------------------------
	wire [7:0] fin_opc = (state == eobd_pkg::EOBD_S_OPC || state == eobd_pkg::EOBD_S_PFX2
		|| state == eobd_pkg::EOBD_S_XOP) ? byte_in : opc;
	eobd_pkg::eobd_class_t fin_class;
	always_comb
	begin
		case (state)
			eobd_pkg::EOBD_S_PFX2:
				fin_class = in_ext ? ext_class : bit_class(byte_in);
			eobd_pkg::EOBD_S_XOP:  fin_class = bit_class(byte_in);
			eobd_pkg::EOBD_S_OPC:  fin_class = main_class;
			eobd_pkg::EOBD_S_HI, eobd_pkg::EOBD_S_LO:
				fin_class = in_ext ? eobd_pkg::EOBD_C_EXTOTHER : eobd_pkg::EOBD_C_MISC;
			default:
				fin_class = (opc[7:6] == 2'd1) ? eobd_pkg::EOBD_C_LOAD8
					: (opc[7:6] == 2'd2) ? eobd_pkg::EOBD_C_ALU
					: (opc[7:6] == 2'd0 && opc[2:0] == 3'd0) ? eobd_pkg::EOBD_C_RELBR
					: (opc == eobd_pkg::EOBD_OP_OUTN) ? eobd_pkg::EOBD_C_PORTOUT
					: (opc == eobd_pkg::EOBD_OP_INN) ? eobd_pkg::EOBD_C_PORTIN
					: eobd_pkg::EOBD_C_MISC;
		endcase
	end

	wire [7:0] rel_adj = byte_in + eobd_pkg::EOBD_BR_ADJ;
	wire       rel_fin = state == eobd_pkg::EOBD_S_IMM && fin_class == eobd_pkg::EOBD_C_RELBR;
	wire [15:0] fin_operand = (state == eobd_pkg::EOBD_S_HI) ? {byte_in, lo}
		: rel_fin ? {{8{rel_adj[7]}}, rel_adj}
		: (state == eobd_pkg::EOBD_S_IMM) ? {8'h0000, byte_in} : 16'h0000;
	wire        fin_uses = state == eobd_pkg::EOBD_S_DISP || state == eobd_pkg::EOBD_S_XOP
		|| (state == eobd_pkg::EOBD_S_IMM && idx != eobd_pkg::EOBD_X_PTR && opc == 8'h0036);
	wire [7:0]  fin_disp = (state == eobd_pkg::EOBD_S_DISP) ? byte_in : disp;

	// Decoded operation register, one cycle pulse of op_valid
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			op_valid <= 1'b0;
			op_class <= eobd_pkg::EOBD_C_MISC;
			op_code <= 8'h0000;
			op_index <= eobd_pkg::EOBD_X_PTR;
			op_group <= 3'h0;
			op_dst <= 3'h0;
			op_src <= 3'h0;
			op_bit <= 3'h0;
			op_imode <= 2'h0;
			op_vector <= 8'h0000;
			op_operand <= 16'h0000;
			op_disp <= 8'h0000;
			op_uses_disp <= 1'b0;
		end
		else
		begin
			op_valid <= finish;
			if (finish)
			begin
				op_class <= fin_class;
				op_code <= fin_opc;
				op_index <= idx;
				op_group <= fin_opc[5:3];
				op_dst <= fin_opc[5:3];
				op_src <= fin_opc[2:0];
				op_bit <= fin_opc[5:3];
				op_imode <= imode_sel;
				op_vector <= {2'b00, fin_opc[5:3], 3'b000};
				op_operand <= fin_operand;
				op_disp <= fin_disp;
				op_uses_disp <= fin_uses;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_halt;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_OPC && byte_in == eobd_pkg::EOBD_OP_HALT)
		|=> op_valid && op_class == eobd_pkg::EOBD_C_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not decoded");

	property p_rel;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_OPC && idx == eobd_pkg::EOBD_X_PTR
			&& byte_in == 8'h0018) ##1 byte_valid
		|=> op_valid && op_operand[7:0] == $past(byte_in) + 8'h0002;
	endproperty
	a_rel: assert property (p_rel) else $error("branch displacement wrong");

	property p_imm16;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_OPC && idx == eobd_pkg::EOBD_X_PTR
			&& byte_in == 8'h0001) ##1 byte_valid[*2]
		|=> op_valid && op_operand == {$past(byte_in), $past(byte_in, 2)};
	endproperty
	a_imm16: assert property (p_imm16) else $error("16-bit operand wrong");

	property p_imm8;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_OPC && idx == eobd_pkg::EOBD_X_PTR
			&& byte_in == 8'h0006) |=> !op_valid ##0 (state == eobd_pkg::EOBD_S_IMM);
	endproperty
	a_imm8: assert property (p_imm8) else $error("immediate byte skipped");

	property p_alu;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_OPC && idx == eobd_pkg::EOBD_X_PTR
			&& byte_in[7:6] == 2'd2 && byte_in[2:0] != 3'd6)
		|=> op_class == eobd_pkg::EOBD_C_ALU && op_group == $past(byte_in[5:3]);
	endproperty
	a_alu: assert property (p_alu) else $error("accumulator group wrong");

	property p_gap;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_PFX2 && !in_ext && byte_in[7:3] == 5'h06)
		|=> op_valid && op_class == eobd_pkg::EOBD_C_UNDEF;
	endproperty
	a_gap: assert property (p_gap) else $error("gap code given a function");

	property p_imode;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_PFX2 && in_ext
			&& byte_in == eobd_pkg::EOBD_EXT_IM2)
		|=> op_class == eobd_pkg::EOBD_C_IMODE && op_imode == 2'd2;
	endproperty
	a_imode: assert property (p_imode) else $error("interrupt mode wrong");

	property p_restart;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_OPC && byte_in == 8'h00FF)
		|=> op_class == eobd_pkg::EOBD_C_RESTART && op_vector == 8'h0038;
	endproperty
	a_restart: assert property (p_restart) else $error("restart vector wrong");

	property p_xbit;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && state == eobd_pkg::EOBD_S_XCB) ##1 byte_valid
		|=> op_valid && op_uses_disp && op_disp == $past(byte_in, 2);
	endproperty
	a_xbit: assert property (p_xbit) else $error("indexed bit displacement lost");

endmodule

// ### tb/eobd_prog_mem.sv
// Program memory model feeding instruction bytes to the decoder
`timescale 1ns/1ps
module eobd_prog_mem
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       byte_ready,
	input  wire logic       slow,
	output logic      [7:0] byte_in = 8'h00,
	output logic            byte_valid = 1'b0
);
	logic [7:0] mem[$];
	int         seed = 32'h20e7_4f09;
	int         r;

	// Queue one byte for fetch
	task automatic push(input logic [7:0] b);
		mem.push_back(b);
	endtask

	// ----------
	// Fetch
	// ----------
	// Random stalls when slow; idle bus toggles so a stale byte never looks valid
	// bytes in order
	always @(posedge clk or posedge sys_rst)
	begin
		r = $random(seed);
		if (sys_rst)
			byte_valid <= 1'b0;
		else if (byte_ready && mem.size() > 0 && !(slow && r[0]))
		begin
			byte_valid <= 1'b1;
			byte_in    <= mem.pop_front();
		end
		else
		begin
			byte_valid <= 1'b0;
			byte_in    <= ~byte_in;
		end
	end
endmodule

// ### tb/eight_bit_opcode_decoder_bench.sv
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
module eight_bit_opcode_decoder_bench;
	typedef struct {
		eobd_pkg::eobd_class_t cls;
		logic [7:0]            code;
		logic                  chk;
		logic [15:0]           opnd;
		logic                  kc;
		eobd_pkg::eobd_idx_t   idx;
		logic                  ud;
		logic [7:0]            disp;
	} eobd_exp_t;

	logic                  clk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  slow = 1'b0;
	logic                  byte_valid, byte_ready, op_valid, op_uses_disp;
	logic [7:0]            byte_in, op_code, op_vector, op_disp, lo, hi;
	logic [2:0]            op_group, op_dst, op_src, op_bit;
	logic [1:0]            op_imode, m;
	logic [15:0]           op_operand;
	eobd_pkg::eobd_class_t op_class;
	eobd_pkg::eobd_idx_t   op_index;
	eobd_exp_t             exq[$];
	eobd_exp_t             e;
	int                    fails = 0;
	int                    total_checks = 0;
	int                    cycles = 0;
	int                    seed = 32'h20e7_4f09;
	int                    i;
	logic [7:0]            imm_op[7] = '{8'h01, 8'h2A, 8'h32, 8'h06, 8'h2E, 8'hD3, 8'hDB};
	logic [7:0]            xpfx[4] = '{8'hDD, 8'hDD, 8'hFD, 8'hED};
	logic [7:0]            xop[4] = '{8'h21, 8'h36, 8'h86, 8'h4B};
	logic [7:0]            one_op[10] = '{8'h46, 8'h56, 8'h5E, 8'h4D, 8'h45,
		8'hF3, 8'hFB, 8'h08, 8'hD9, 8'hC9};
	eobd_pkg::eobd_class_t one_cls[10] = '{eobd_pkg::EOBD_C_IMODE,
		eobd_pkg::EOBD_C_IMODE, eobd_pkg::EOBD_C_IMODE, eobd_pkg::EOBD_C_RETM,
		eobd_pkg::EOBD_C_RETNM, eobd_pkg::EOBD_C_IDIS, eobd_pkg::EOBD_C_IENA,
		eobd_pkg::EOBD_C_EXAF, eobd_pkg::EOBD_C_PAIRSW, eobd_pkg::EOBD_C_MISC};

	// 250 MHz clock
	always #2 clk = ~clk;

	// Decoder and its program memory
	eobd_decoder i_eobd_decoder
	(
		.clk, .sys_rst, .byte_in, .byte_valid, .byte_ready, .op_valid, .op_class,
		.op_code, .op_index, .op_group, .op_dst, .op_src, .op_bit, .op_imode,
		.op_vector, .op_operand, .op_disp, .op_uses_disp
	);
	eobd_prog_mem i_eobd_prog_mem
	(
		.clk, .sys_rst, .byte_ready, .slow, .byte_in, .byte_valid
	);

	// ----------
	// Helpers
	// ----------
	// Bytes go out in the order they are queued
	task automatic put(input logic [7:0] b);
		i_eobd_prog_mem.push(b);
	endtask

	// Note one expected decode; kc low leaves the class open
	task automatic want(input eobd_pkg::eobd_class_t c, input logic [7:0] code,
		input logic k = 1'b0, input logic [15:0] o = 16'h0000, input logic kc = 1'b1,
		input eobd_pkg::eobd_idx_t x = eobd_pkg::EOBD_X_PTR, input logic u = 1'b0,
		input logic [7:0] dd = 8'h00);
		eobd_exp_t t;
		t = '{c, code, k, o, kc, x, u, dd};
		exq.push_back(t);
	endtask

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Expected class for the swept maps
	function automatic eobd_pkg::eobd_class_t ref_cls(input logic [7:0] p, input logic [7:0] b);
		if (p == 8'hCB && b[7:3] == 5'h06)
			return eobd_pkg::EOBD_C_UNDEF;
		if (p == 8'hCB)
			return eobd_pkg::eobd_class_t'({3'h1, b[7:6]});
		if (p == 8'hED)
			return b[2] ? eobd_pkg::EOBD_C_EXTOTHER : eobd_pkg::EOBD_C_BLOCK;
		if (b == 8'h76)
			return eobd_pkg::EOBD_C_HALT;
		return b[7] ? eobd_pkg::EOBD_C_ALU : eobd_pkg::EOBD_C_LOAD8;
	endfunction

	// Oldest note against each decode; cycle ceiling ends a hang
	always @(posedge clk)
	begin
		if (!sys_rst && op_valid === 1'b1)
		begin
			if (exq.size() == 0)
				chk(1'b0, "unexpected decode");
			else
			begin
				e = exq.pop_front();
				m = e.code == 8'h5E ? 2'h2 : {1'b0, e.code == 8'h56};
				chk((!e.kc || op_class === e.cls) && op_code === e.code, "class");
				chk(op_index === e.idx && op_uses_disp === e.ud, "index");
				chk(!e.ud || op_disp === e.disp, "displacement");
				chk(!e.chk || op_operand === e.opnd, "operand");
				chk({op_group, op_dst, op_bit} === {3{e.code[5:3]}}, "fields");
				chk(op_src === e.code[2:0], "source");
				chk(byte_ready === 1'b1, "ready");
				chk(e.cls != eobd_pkg::EOBD_C_IMODE || op_imode === m, "mode");
				chk(e.cls != eobd_pkg::EOBD_C_RESTART || op_vector === {2'h0, e.code[5:3], 3'h0},
					"vector");
			end
		end
		cycles++;
		if (cycles == 20000)
		begin
			chk(1'b0, "timeout");
			summarize();
		end
	end

	// ----------
	// Stimulus
	// ----------
	// Back-to-back sweeps first, then stalled fetches
	initial
	begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 8'h40; i < 8'hC0; i++)
		begin
			put(i[7:0]);
			want(ref_cls(8'h00, i[7:0]), i[7:0]);
		end
		for (i = 0; i < 256; i++)
		begin
			put(8'hCB);
			put(i[7:0]);
			want(ref_cls(8'hCB, i[7:0]), i[7:0]);
		end
		for (i = 8'hA0; i < 8'hBC; i++)
		begin
			put(8'hED);
			put(i[7:0]);
			want(ref_cls(8'hED, i[7:0]), i[7:0]);
		end
		// Back-to-back multi-byte forms so the sequence checks see them
		put(8'h01);
		put(8'h34);
		put(8'h12);
		want(eobd_pkg::EOBD_C_MISC, 8'h01, 1'b1, 16'h1234, 1'b0);
		put(8'h18);
		put(8'hF0);
		want(eobd_pkg::EOBD_C_RELBR, 8'h18, 1'b1, 16'hFFF2);
		put(8'hDD);
		put(8'hCB);
		put(8'h05);
		put(8'h4E);
		want(eobd_pkg::EOBD_C_BITTEST, 8'h4E, 1'b0, 16'h0000, 1'b1,
			eobd_pkg::EOBD_X_IDX1, 1'b1, 8'h05);
		while (exq.size() > 0)
			@(posedge clk);
		slow <= 1'b1;
		for (i = 0; i < 10; i++)
		begin
			if (i < 5)
				put(8'hED);
			put(one_op[i]);
			want(one_cls[i], one_op[i]);
		end
		for (i = 0; i < 8; i++)
		begin
			lo = $random(seed);
			lo = lo[7:1] == 7'h3F ? 8'h00 : lo; // Keep d+2 inside one byte
			hi = {2'h0, i[2:0], 3'h0};
			put({2'h3, i[2:0], 3'h7});
			want(eobd_pkg::EOBD_C_RESTART, {2'h3, i[2:0], 3'h7});
			if (i > 1)
			begin
				put(hi);
				put(lo);
				want(eobd_pkg::EOBD_C_RELBR, hi, 1'b1, {{8{lo[7]}}, lo} + 16'h0002);
			end
		end
		for (i = 0; i < 7; i++)
		begin
			lo = $random(seed);
			hi = $random(seed);
			put(imm_op[i]);
			put(lo);
			if (i < 3)
				put(hi);
			want(i == 5 ? eobd_pkg::EOBD_C_PORTOUT : eobd_pkg::EOBD_C_PORTIN, imm_op[i], 1'b1,
				i < 3 ? {hi, lo} : {8'h00, lo}, i > 4);
		end
		for (i = 0; i < 8; i++)
		begin
			lo = $random(seed);
			hi = {i[2:1], lo[5:3], 3'h6};
			put(i[0] ? 8'hFD : 8'hDD);
			put(8'hCB);
			put(lo);
			put(hi);
			want(ref_cls(8'hCB, hi), hi, 1'b0, 16'h0000, 1'b1, i[0] ? eobd_pkg::EOBD_X_IDX2 :
				eobd_pkg::EOBD_X_IDX1, 1'b1, lo);
		end
		for (i = 0; i < 4; i++)
		begin
			lo = $random(seed);
			hi = $random(seed);
			put(xpfx[i]);
			put(xop[i]);
			put(lo);
			if (i != 2)
				put(hi);
			want(eobd_pkg::EOBD_C_ALU, xop[i], i != 2, i == 1 ? {8'h00, hi} : {hi, lo},
				i == 2, i == 2 ? eobd_pkg::EOBD_X_IDX2 : i == 3 ? eobd_pkg::EOBD_X_PTR :
				eobd_pkg::EOBD_X_IDX1, i == 1 || i == 2, lo);
		end
		while (exq.size() > 0)
			@(posedge clk);
		repeat (10) @(posedge clk);
		summarize();
	end
endmodule
